// file: hdl/ocr_pkg.sv
// How it works
// R1: Signed six-bit offset added per channel
// R2: Format code picks binary, twos, gray coding
// R3: Global type bit: 0 CMOS, 1 LVDS
// R4: Phase field delays divider zero to six
// R5: Five-bit data clock delay, steps of 2500/31
// R6: Per-channel invert and active-low output enable
// R7: Self-test enable, restart, readable 16-bit signature
// R8: Local writes reach only indexed channels
// R9: Transfer bit copies staged values to active
package ocr_pkg;
   localparam logic [9:0] ADDR_CHAN_INDEX   = 10'h0_005; // Channel index
   localparam logic [9:0] ADDR_SELF_TEST    = 10'h0_00e; // Self-test control
   localparam logic [9:0] ADDR_OFFSET       = 10'h0_010; // Offset adjust
   localparam logic [9:0] ADDR_OUT_MODE     = 10'h0_014; // Output mode
   localparam logic [9:0] ADDR_CLK_PHASE    = 10'h0_016; // Clock phase control
   localparam logic [9:0] ADDR_DCLK_DELAY   = 10'h0_017; // Data clock output delay
   localparam logic [9:0] ADDR_REF_SEL      = 10'h0_018; // Reference select
   localparam logic [9:0] ADDR_SIG_LOW      = 10'h0_024; // Signature low byte
   localparam logic [9:0] ADDR_SIG_HIGH     = 10'h0_025; // Signature high byte
   localparam logic [9:0] ADDR_TRANSFER     = 10'h0_0ff; // Transfer
   localparam logic [7:0] RST_CHAN_INDEX    = 8'h03;     // Both channels selected
   localparam logic [7:0] RST_ZERO          = 8'h00;     // Common zero default
   localparam logic [7:0] RST_REF_SEL       = 8'hc0;     // 2.0 V p-p default
   localparam logic [7:0] MASK_SELF_TEST    = 8'h05;     // Bits 2 and 0 live
   localparam logic [7:0] MASK_OFFSET       = 8'h3f;     // Six-bit offset
   localparam logic [7:0] MASK_OUT_MODE     = 8'hd7;     // Bits 7,6,4,2,1,0
   localparam logic [7:0] MASK_CLK_PHASE    = 8'h87;     // Bit 7 and 2:0
   localparam logic [7:0] MASK_DCLK_DELAY   = 8'h1f;     // Five-bit delay
   localparam logic [7:0] MASK_REF_SEL      = 8'hc0;     // Two top bits
   localparam logic [7:0] MASK_CHAN_INDEX   = 8'h03;     // Two channel bits
   localparam logic [7:0] MASK_MODE_GLOB    = 8'hc0;     // Shared output mode bits
   localparam logic [7:0] MASK_MODE_LOCAL   = 8'h17;     // Per-channel output mode bits
   localparam int         BIT_ST_EN         = 0;         // Self-test enable
   localparam int         BIT_ST_RESTART    = 2;         // Self-test restart
   localparam int         BIT_TRANSFER      = 0;         // Transfer bit
   localparam int         BIT_OUT_INV       = 2;         // Output invert
   localparam int         BIT_OUT_EN_N      = 4;         // Output enable bar
   localparam int         BIT_OUT_TYPE      = 6;         // Output type
   localparam int         BIT_DRIVE         = 7;         // Drive strength
   localparam int         BIT_DCLK_INV      = 7;         // Invert data clock
   localparam logic [2:0] PHASE_MAX         = 3'h6;      // Largest legal phase code
   localparam int         DELAY_RANGE_PS    = 2500;      // Data clock delay span
   localparam int         DELAY_STEPS       = 31;        // Steps in that span
   localparam logic [1:0] FMT_OFFSET_BIN    = 2'h0;      // Offset binary
   localparam logic [1:0] FMT_TWOS          = 2'h1;      // Twos complement
   localparam logic [1:0] FMT_GRAY          = 2'h2;      // Gray code
   localparam logic [15:0] SIG_SEED         = 16'h0001;  // Signature seed, arbitrary
   localparam logic [15:0] SIG_POLY         = 16'h1021;  // Signature feedback taps
   localparam int          NCH              = 2;         // Channels

   // Active settings of one channel
   typedef struct packed {
      logic [5:0] offset;    // Signed offset in LSBs
      logic [1:0] fmt;       // Output coding
      logic       invert;    // Output inversion
      logic       en_n;      // Output disable
      logic       st_en;     // Self-test enable
      logic       st_restart;// Self-test restart
   } ocr_chan_t;

   // Active global settings
   typedef struct packed {
      logic       out_lvds;  // 1 LVDS, 0 CMOS
      logic       drive;     // Drive strength select
      logic [2:0] phase;     // Divider delay in input clocks
      logic       dclk_inv;  // Invert data clock output
      logic [4:0] dclk_dly;  // Data clock delay code
      logic [1:0] ref_sel;   // Reference range
   } ocr_glob_t;
endpackage

// file: hdl/ocr_chan.sv
`timescale 1ns/1ns
// One channel datapath: offset, coding, inversion, enable, self-test
module ocr_chan
(
   input  wire logic              core_clk,   // Core clock
   input  wire logic              nrst,       // Sync reset, active low
   input  wire logic              ce,         // Clock enable
   input  wire ocr_pkg::ocr_chan_t cfg,       // Active channel settings
   input  wire logic [9:0]        sample_in,  // Raw offset-binary sample
   output logic [9:0]             data_out,   // Coded output sample
   output logic                   data_oe,    // Output driven
   output logic [15:0]            signature   // Self-test signature
);
   logic [9:0]  data_reg;       // Output sample
   logic [9:0]  data_next;
   logic        oe_reg;         // Output enable
   logic        oe_next;
   logic [15:0] sig_reg;        // Signature shift register
   logic [15:0] sig_next;
   logic [10:0] sum;            // Offset-corrected sum, one guard bit
   logic [9:0]  corr;           // Saturated corrected sample
   logic [9:0]  coded;          // After coding

   // Datapath and signature next values
   always_comb
   begin
      // R1: signed offset add
      sum = {1'b0, sample_in} + {{5{cfg.offset[5]}}, cfg.offset};
      // Saturate rather than wrap, so a large offset never flips full scale
      // A negative offset that goes below zero borrows into the guard bit
      if (cfg.offset[5] && sum[10])
         corr = 10'h000;
      else if (!cfg.offset[5] && sum[10])
         corr = 10'h3ff;
      else
         corr = sum[9:0];
      // R2: pick the coding
      unique case (cfg.fmt)
         ocr_pkg::FMT_TWOS: coded = {~corr[9], corr[8:0]};
         ocr_pkg::FMT_GRAY: coded = corr ^ (corr >> 1);
         default:           coded = corr;   // 00 and 11 both offset binary
      endcase
      // R6: invert and disable
      data_next = cfg.invert ? ~coded : coded;
      oe_next   = ~cfg.en_n;
      // R7: self-test signature accumulation
      sig_next = sig_reg;
      if (cfg.st_restart)
         sig_next = ocr_pkg::SIG_SEED;
      else if (cfg.st_en)
         sig_next = ({sig_reg[14:0], 1'b0} ^ (sig_reg[15] ? ocr_pkg::SIG_POLY : 16'h0000))
                    ^ {6'h00, data_next};
   end

   // Register stage
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         data_reg <= 10'h000;
         oe_reg   <= 1'b0;
         sig_reg  <= 16'h0000;
      end
      else if (ce)
      begin
         data_reg <= data_next;
         oe_reg   <= oe_next;
         sig_reg  <= sig_next;
      end
   end

   assign data_out  = data_reg;
   assign data_oe   = oe_reg;
   assign signature = sig_reg;
endmodule

// file: hdl/ocr_regs.sv
`timescale 1ns/1ns
// Register bank behind the serial control port, two channels
// Writes land in staged registers; a write of the transfer bit copies them
// into the active set that drives the channel datapaths and global outputs.
// Reads of settings show the staged values, never the active ones; signature reads show the live datapath signatures.
module ocr_regs
(
   input  wire logic                  core_clk,     // Serial port clock
   input  wire logic                  nrst,         // Sync reset, active low
   input  wire logic                  ce,           // Clock enable
   input  wire logic                  wr_en,        // Write strobe, one cycle
   input  wire logic                  rd_en,        // Read strobe, one cycle
   input  wire logic [9:0]            addr,         // Register address
   input  wire logic [7:0]            wdata,        // Write data
   input  wire logic [1:0][9:0]       sample_in,    // Raw samples per channel
   output logic [7:0]                 rdata,        // Read data
   output logic                       rvalid,       // Read data valid
   output logic [1:0][9:0]            data_out,     // Coded samples
   output logic [1:0]                 data_oe,      // Channel output enables
   output ocr_pkg::ocr_glob_t         glob_out      // Active global settings
);
   // Staged (master) registers, per channel where local.
   // The datapath never looks at these, so a half-written set of fields
   // cannot reach the outputs before software asks for a transfer.
   logic [7:0]            idx_reg, idx_next;          // Channel index
   logic [1:0][7:0]       st_reg, st_next;            // Self-test control
   logic [1:0][7:0]       ofs_reg, ofs_next;          // Offset adjust
   logic [1:0][7:0]       mode_reg, mode_next;        // Output mode, local part
   logic [7:0]            gmode_reg, gmode_next;      // Output mode, global part
   logic [7:0]            phase_reg, phase_next;      // Clock phase control
   logic [7:0]            dly_reg, dly_next;          // Data clock delay
   logic [7:0]            ref_reg, ref_next;          // Reference select
   // Active (slave) copies, loaded only by a transfer; restart bits clear again a cycle later. All channels load
   // together so both datapaths switch on the same edge.
   ocr_pkg::ocr_chan_t [1:0] act_reg, act_next;       // Active channel settings
   ocr_pkg::ocr_glob_t       glob_reg, glob_next;     // Active global settings
   logic [7:0]            rdata_reg, rdata_next;      // Read data
   logic                  rvalid_reg, rvalid_next;    // Read valid
   logic [1:0][15:0]      sig;                        // Channel signatures
   logic                  xfer;                       // Transfer strobe
   logic [0:0]            rsel;                       // Channel read back

   // Staged register writes and transfer
   always_comb
   begin
      // Hold every staged register unless written
      idx_next   = idx_reg;
      st_next    = st_reg;
      ofs_next   = ofs_reg;
      mode_next  = mode_reg;
      gmode_next = gmode_reg;
      phase_next = phase_reg;
      dly_next   = dly_reg;
      ref_next   = ref_reg;
      // R9: transfer strobe
      // Decoded from the live bus so the copy happens on the write edge itself;
      // the transfer register has no storage and so reads back as zero
      xfer = wr_en && addr == ocr_pkg::ADDR_TRANSFER && wdata[ocr_pkg::BIT_TRANSFER];
      // Global registers take every write
      if (wr_en)
      begin
         unique case (addr)
            // Only the two channel bits exist
            ocr_pkg::ADDR_CHAN_INDEX: idx_next = wdata & ocr_pkg::MASK_CHAN_INDEX;
            // Global half of output mode ignores the channel index
            ocr_pkg::ADDR_OUT_MODE:
               gmode_next = wdata & ocr_pkg::MASK_OUT_MODE & ocr_pkg::MASK_MODE_GLOB;
            ocr_pkg::ADDR_CLK_PHASE:
               // R4: codes above six are clamped
               // Clamping keeps the invert bit and drops the open bits
               phase_next = (wdata[2:0] > ocr_pkg::PHASE_MAX)
                            ? {wdata[7], 4'h0, ocr_pkg::PHASE_MAX}
                            : (wdata & ocr_pkg::MASK_CLK_PHASE);
            // R5: five-bit delay code
            ocr_pkg::ADDR_DCLK_DELAY: dly_next = wdata & ocr_pkg::MASK_DCLK_DELAY;
            // Reference range lives in the top two bits
            ocr_pkg::ADDR_REF_SEL:    ref_next = wdata & ocr_pkg::MASK_REF_SEL;
            // Local, read-only and unmapped addresses fall through
            default: ;
         endcase
      end
      // R8: local writes gated by channel index
      for (int c = 0; c < ocr_pkg::NCH; c++)
      begin
         // A channel whose index bit is clear keeps its staged value, so software
         // can give the two channels different settings before one transfer
         if (wr_en && idx_reg[c])
         begin
            if (addr == ocr_pkg::ADDR_SELF_TEST)
               st_next[c] = wdata & ocr_pkg::MASK_SELF_TEST;
            if (addr == ocr_pkg::ADDR_OFFSET)
               ofs_next[c] = wdata & ocr_pkg::MASK_OFFSET;
            if (addr == ocr_pkg::ADDR_OUT_MODE)
               // Local half: enable bar, invert, format
               mode_next[c] = wdata & ocr_pkg::MASK_OUT_MODE & ocr_pkg::MASK_MODE_LOCAL;
         end
      end
      // R9: copy staged values into active set
      // A transfer with bit 0 clear does nothing
      act_next  = act_reg;
      glob_next = glob_reg;
      if (xfer)
      begin
         // Every channel loads, whatever the index; the index steers only writes and read back
         for (int c = 0; c < ocr_pkg::NCH; c++)
         begin
            act_next[c].offset     = ofs_reg[c][5:0];
            act_next[c].fmt        = mode_reg[c][1:0];
            act_next[c].invert     = mode_reg[c][ocr_pkg::BIT_OUT_INV];
            act_next[c].en_n       = mode_reg[c][ocr_pkg::BIT_OUT_EN_N];
            act_next[c].st_en      = st_reg[c][ocr_pkg::BIT_ST_EN];
            act_next[c].st_restart = st_reg[c][ocr_pkg::BIT_ST_RESTART];
         end
         // R3: global output type
         // Phase, delay and reference steer circuits outside this block
         glob_next.out_lvds = gmode_reg[ocr_pkg::BIT_OUT_TYPE];
         glob_next.drive    = gmode_reg[ocr_pkg::BIT_DRIVE];
         glob_next.phase    = phase_reg[2:0];
         glob_next.dclk_inv = phase_reg[ocr_pkg::BIT_DCLK_INV];
         glob_next.dclk_dly = dly_reg[4:0];
         glob_next.ref_sel  = ref_reg[7:6];
      end
      else
      begin
         // Restart is a one-shot so the signature does not stay pinned
         for (int c = 0; c < ocr_pkg::NCH; c++)
            act_next[c].st_restart = 1'b0;
      end
   end

   // Read back; local registers show the lowest indexed channel
   // Reading is registered so rdata stands until the next read; a local
   // read with no channel selected shows channel B
   always_comb
   begin
      // Channel A wins when both index bits are set
      rsel        = idx_reg[0] ? 1'b0 : 1'b1;
      // Valid is a one-cycle echo of the strobe
      rvalid_next = rd_en;
      // Last read data holds between reads
      rdata_next  = rdata_reg;
      if (rd_en)
      begin
         unique case (addr)
            ocr_pkg::ADDR_CHAN_INDEX: rdata_next = idx_reg;
            ocr_pkg::ADDR_SELF_TEST:  rdata_next = st_reg[rsel];
            ocr_pkg::ADDR_OFFSET:     rdata_next = ofs_reg[rsel];
            // Global and local halves of output mode share one byte
            ocr_pkg::ADDR_OUT_MODE:   rdata_next = gmode_reg | mode_reg[rsel];
            ocr_pkg::ADDR_CLK_PHASE:  rdata_next = phase_reg;
            ocr_pkg::ADDR_DCLK_DELAY: rdata_next = dly_reg;
            ocr_pkg::ADDR_REF_SEL:    rdata_next = ref_reg;
            // R7: read-only signature bytes
            ocr_pkg::ADDR_SIG_LOW:    rdata_next = sig[rsel][7:0];
            ocr_pkg::ADDR_SIG_HIGH:   rdata_next = sig[rsel][15:8];
            // Transfer and unmapped addresses read as zero
            default:                  rdata_next = ocr_pkg::RST_ZERO;
         endcase
      end
   end

   // Register everything
   // Synchronous reset; ce low freezes every register, staged and active alike
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         // Staged set
         idx_reg    <= ocr_pkg::RST_CHAN_INDEX;
         st_reg     <= '0;
         ofs_reg    <= '0;
         mode_reg   <= '0;
         gmode_reg  <= ocr_pkg::RST_ZERO;
         phase_reg  <= ocr_pkg::RST_ZERO;
         dly_reg    <= ocr_pkg::RST_ZERO;
         ref_reg    <= ocr_pkg::RST_REF_SEL;
         act_reg    <= '0;
         // Active reference matches the staged default
         glob_reg   <= '{ref_sel: ocr_pkg::RST_REF_SEL[7:6], default: '0};
         rdata_reg  <= ocr_pkg::RST_ZERO;
         rvalid_reg <= 1'b0;
      end
      else if (ce)
      begin
         // Staged set
         idx_reg    <= idx_next;
         st_reg     <= st_next;
         ofs_reg    <= ofs_next;
         mode_reg   <= mode_next;
         gmode_reg  <= gmode_next;
         phase_reg  <= phase_next;
         dly_reg    <= dly_next;
         ref_reg    <= ref_next;
         // Active set and read port
         act_reg    <= act_next;
         glob_reg   <= glob_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // One datapath per channel
   // The channels share the clock enable so their samples stay aligned
   for (genvar c = 0; c < ocr_pkg::NCH; c++)
   begin : g_chan
      ocr_chan u_chan
      (
         .core_clk  (core_clk),
         .nrst      (nrst),
         .ce        (ce),
         .cfg       (act_reg[c]),
         .sample_in (sample_in[c]),
         .data_out  (data_out[c]),
         .data_oe   (data_oe[c]),
         .signature (sig[c])
      );
   end

   // Outputs come straight from registers
   assign rdata    = rdata_reg;
   assign rvalid   = rvalid_reg;
   assign glob_out = glob_reg;
endmodule

// file: testbench/ocr_regs_properties.sv
`timescale 1ns/1ns
// Port-level checks of the register bank
module ocr_regs_props
(
   input wire logic               core_clk,  // Clock
   input wire logic               nrst,      // Sync reset, active low
   input wire logic               ce,        // Clock enable
   input wire logic               wr_en,     // Write strobe
   input wire logic               rd_en,     // Read strobe
   input wire logic [9:0]         addr,      // Address
   input wire logic [7:0]         wdata,     // Write data
   input wire logic [1:0][9:0]    sample_in, // Raw samples
   input wire logic [7:0]         rdata,     // Read data
   input wire logic               rvalid,    // Read valid
   input wire logic [1:0][9:0]    data_out,  // Coded samples
   input wire logic [1:0]         data_oe,   // Output enables
   input wire ocr_pkg::ocr_glob_t glob_out   // Global settings
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic rd_go; // A read is taken
   logic xfer;  // A transfer is taken
   assign rd_go = rd_en && ce;
   assign xfer  = wr_en && ce && addr == ocr_pkg::ADDR_TRANSFER && wdata[ocr_pkg::BIT_TRANSFER];
   a_read_valid_pulse:
      assert property (ce |=> rvalid == $past(rd_en)) else $error("rvalid not one cycle");
   a_rdata_holds:
      assert property (!rd_go |=> $stable(rdata)) else $error("rdata moved without read");
   a_transfer_reads_zero:
      assert property (rd_go && addr == ocr_pkg::ADDR_TRANSFER |=> rdata == 8'h00)
         else $error("transfer register read nonzero");
   a_unmapped_zero:
      assert property (rd_go && addr > ocr_pkg::ADDR_SIG_HIGH && !addr[8] && !addr[9]
         && addr != ocr_pkg::ADDR_TRANSFER |=> rdata == 8'h00) else $error("unmapped read");
   a_offset_field_width:
      assert property (rd_go && addr == ocr_pkg::ADDR_OFFSET |=> rdata[7:6] == 2'h0)
         else $error("offset open bits set");
   a_delay_field_width:
      assert property (rd_go && addr == ocr_pkg::ADDR_DCLK_DELAY |=> rdata[7:5] == 3'h0)
         else $error("delay open bits set");
   a_phase_clamped:
      assert property (glob_out.phase <= ocr_pkg::PHASE_MAX) else $error("phase above six");
   a_glob_staged:
      assert property (!xfer |=> $stable(glob_out)) else $error("global moved without transfer");
   a_enable_staged:
      assert property (!xfer ##1 !xfer |=> $stable(data_oe)) else $error("enable moved");
   c_transfer: cover property (xfer);
   c_sig_read: cover property (rd_go && addr == ocr_pkg::ADDR_SIG_HIGH);
   c_phase_top: cover property (glob_out.phase == ocr_pkg::PHASE_MAX);
endmodule
bind ocr_regs ocr_regs_props ocr_regs_props_i (.core_clk(core_clk), .nrst(nrst), .ce(ce),
   .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .sample_in(sample_in),
   .rdata(rdata), .rvalid(rvalid), .data_out(data_out), .data_oe(data_oe), .glob_out(glob_out));

// file: testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic               core_clk  = 1'b0;    // 25 MHz clock
   logic               nrst      = 1'b0;    // Reset held at start
   logic               ce        = 1'b1;    // Running except in the clock enable test
   logic               wr_en     = 1'b0;    // Write strobe
   logic               rd_en     = 1'b0;    // Read strobe
   logic [9:0]         addr      = 10'h000; // Address
   logic [7:0]         wdata     = 8'h00;   // Write data
   logic [1:0][9:0]    sample_in = {10'h13a, 10'h2c5}; // B, A
   logic [7:0]         rdata, rval;         // Read data, captured copy
   logic               rvalid;              // Read valid
   logic [1:0][9:0]    data_out;            // Coded samples
   logic [1:0]         data_oe;             // Output enables
   ocr_pkg::ocr_glob_t glob_out;            // Global settings
   logic [15:0]        sig, sig1;           // Signatures
   int                 n_errors = 0, n_compared = 0, cyc = 0;
   // Reset table: address and expected value; 0x030 is unmapped
   logic [17:0] tab [10] = '{{10'h005, 8'h03}, {10'h00e, 8'h00}, {10'h010, 8'h00},
      {10'h014, 8'h00}, {10'h017, 8'h00}, {10'h018, 8'hc0}, {10'h024, 8'h00},
      {10'h025, 8'h00}, {10'h0ff, 8'h00}, {10'h030, 8'h00}};
   ocr_regs ocr_regs_i (.core_clk(core_clk), .nrst(nrst), .ce(ce), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata), .sample_in(sample_in), .rdata(rdata),
      .rvalid(rvalid), .data_out(data_out), .data_oe(data_oe), .glob_out(glob_out));
   always #20 core_clk = ~core_clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Strobes are held across exactly one sampling edge
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #2 wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(posedge core_clk);
      #2 wr_en = 1'b0;
   endtask
   task automatic rdr(input logic [9:0] a);
      @(posedge core_clk);
      #2 rd_en = 1'b1;
      addr = a;
      @(posedge core_clk);
      #2 rd_en = 1'b0;
      rval = rdata;
      chk(rvalid, 16'h0001, "rvalid");
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      rdr(a);
      chk(rval, exp, "read");
   endtask
   task automatic xfer;
      wr(10'h0ff, 8'h01);
   endtask
   // Active copy and output register need two edges; three gives margin
   task automatic settle;
      repeat (3) @(posedge core_clk);
      #2;
   endtask
   task automatic outs(input logic [9:0] ea, input logic [9:0] eb);
      settle;
      chk(data_out[0], ea, "channel a");
      chk(data_out[1], eb, "channel b");
   endtask
   function automatic logic [9:0] coded(input logic [9:0] v, input logic [1:0] f);
      return (f == 2'h1) ? (v ^ 10'h200) : (f == 2'h2) ? (v ^ (v >> 1)) : v;
   endfunction
   // Run self-test from a restart for a fixed span, stop it, read signature
   task automatic st_run;
      wr(10'h00e, 8'h05);
      xfer;
      repeat (20) @(posedge core_clk);
      wr(10'h00e, 8'h00);
      xfer;
      settle;
      rdr(10'h024);
      sig[7:0] = rval;
      rdr(10'h025);
      sig[15:8] = rval;
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles the tests use
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         $display("unexpected at %0t: timeout", $time);
         close_out;
      end
   end
   initial
   begin
      repeat (3) @(posedge core_clk);
      #2 nrst = 1'b1;
      foreach (tab[i]) rd(tab[i][17:8], tab[i][7:0]);
      chk(glob_out.ref_sel, 16'h0003, "ref");
      outs(10'h2c5, 10'h13a);
      chk(data_oe, 16'h0003, "oe");
      $display("test reset done");
      wr(10'h010, 8'h01);
      rd(10'h010, 8'h01);
      outs(10'h2c5, 10'h13a);
      xfer;
      outs(10'h2c6, 10'h13b);
      $display("test staging done");
      @(posedge core_clk);
      #2 sample_in = {10'h010, 10'h3f0};
      wr(10'h010, 8'h1f);
      xfer;
      outs(10'h3ff, 10'h02f);
      wr(10'h005, 8'h02);
      wr(10'h010, 8'h20);
      xfer;
      outs(10'h3ff, 10'h000);
      rd(10'h010, 8'h20);
      wr(10'h005, 8'h01);
      rd(10'h010, 8'h1f);
      wr(10'h010, 8'h00);
      $display("test offset done");
      for (int f = 0; f < 4; f++)
      begin
         wr(10'h014, 8'(f));
         xfer;
         outs(coded(10'h3f0, 2'(f)), 10'h000);
      end
      wr(10'h014, 8'h04);
      xfer;
      outs(10'h00f, 10'h000);
      wr(10'h014, 8'hd0);
      rd(10'h014, 8'hd0);
      xfer;
      settle;
      chk(data_oe, 16'h0002, "oe");
      chk(glob_out.out_lvds, 16'h0001, "type");
      chk(glob_out.drive, 16'h0001, "drive");
      wr(10'h014, 8'h00);
      xfer;
      settle;
      chk(glob_out.out_lvds, 16'h0000, "type");
      chk(glob_out.drive, 16'h0000, "drive");
      $display("test output mode done");
      for (int p = 0; p < 8; p++)
      begin
         wr(10'h016, 8'h80 | 8'(p));
         xfer;
         settle;
         chk(glob_out.phase, (p > 6) ? 16'h0006 : 16'(p), "phase");
      end
      chk(glob_out.dclk_inv, 16'h0001, "dclk invert");
      wr(10'h017, 8'hff);
      rd(10'h017, 8'h1f);
      wr(10'h018, 8'h40);
      xfer;
      settle;
      chk(glob_out.dclk_dly, 16'h001f, "delay");
      chk(glob_out.ref_sel, 16'h0001, "ref");
      $display("test globals done");
      // Clock enable low: a write in that time must not land
      @(posedge core_clk);
      #2 ce = 1'b0;
      wr(10'h017, 8'h05);
      settle;
      chk(glob_out.dclk_dly, 16'h001f, "frozen delay");
      ce = 1'b1;
      rd(10'h017, 8'h1f);
      $display("test clock enable done");
      wr(10'h024, 8'hff);
      rd(10'h024, 8'h00);
      wr(10'h005, 8'h03);
      st_run;
      sig1 = sig;
      st_run;
      chk(sig, sig1, "restart");
      chk(16'(sig1 != 16'h0000), 16'h0001, "signature");
      rd(10'h024, sig1[7:0]);
      $display("test self-test done");
      close_out;
   end
endmodule
